// ### hdl/dcd_cmd_decoder.v
// display controller command decoder with ahb-lite register port
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "dcd_defs.vh"
module dcd_cmd_decoder (
    input wire sys_clk_i,
    input wire rst_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output wire [31:0] hrdata_o,
    output wire hreadyout_o,
    output wire hresp_o,
    output wire [19:0] mem_addr_o,
    output wire [23:0] mem_wdata_o,
    output wire mem_we_o,
    output wire mem_re_o,
    input wire [23:0] mem_rdata_i,
    input wire [15:0] scan_line_i,
    input wire line_start_i,
    input wire vfp_start_i,
    output wire tear_o,
    input wire [3:0] gpio_i,
    output wire [3:0] gpio_o,
    output wire [3:0] gpio_oe_o,
    output wire [3:0] gen_o,
    output wire [7:0] addr_mode_o,
    output wire [15:0] panel_mode_o,
    output wire [15:0] vert_total_o,
    output wire [15:0] vert_start_o,
    output wire [31:0] post_proc_o,
    output wire [7:0] bl_conf_o,
    input wire pll_lock_i,
    output wire pll_en_o,
    output wire clk_sel_pll_o,
    output wire [23:0] pll_cfg_o,
    output wire [23:0] pixclk_cfg_o,
    output wire deep_sleep_o
);

// =====================================================
// helpers
function [4:0] slot_of;
    input [7:0] c;
    begin
        case (c)
            `DCD_C_CASET: slot_of = `DCD_S_CASET;
            `DCD_C_PASET: slot_of = `DCD_S_PASET;
            `DCD_C_AMODE: slot_of = `DCD_S_AMODE;
            `DCD_C_TLINE: slot_of = `DCD_S_TLINE;
            `DCD_C_PMODE: slot_of = `DCD_S_PMODE;
            `DCD_C_VPER: slot_of = `DCD_S_VPER;
            `DCD_C_PCONF: slot_of = `DCD_S_PCONF;
            `DCD_C_PVAL: slot_of = `DCD_S_PVAL;
            `DCD_C_POST: slot_of = `DCD_S_POST;
            `DCD_C_BLCONF: slot_of = `DCD_S_BLCONF;
            `DCD_C_BLLIM: slot_of = `DCD_S_BLLIM;
            `DCD_C_PLLGO: slot_of = `DCD_S_PLLGO;
            `DCD_C_PLLCF: slot_of = `DCD_S_PLLCF;
            `DCD_C_PCLK: slot_of = `DCD_S_PCLK;
            default:
            begin
                if (c[7:4] == `DCD_C_GENGRP && !c[0])
                    slot_of = (c[3] ? `DCD_S_COMB0 : `DCD_S_GEN0)
                        + {3'h0, c[2:1]};
                else
                    slot_of = `DCD_S_NONE;
            end
        endcase
    end
endfunction

// query codes read the slot of their paired set code
function [4:0] get_slot;
    input [7:0] c;
    begin
        if (c == `DCD_C_GAMODE)
            get_slot = `DCD_S_AMODE;
        else if (c[0] && c >= `DCD_C_GETMIN)
            get_slot = slot_of(c - 8'h01);
        else
            get_slot = `DCD_S_NONE;
    end
endfunction

// next pixel inside the column/page window
function [19:0] adv;
    input [19:0] p;
    input [9:0] sc;
    input [9:0] ec;
    input [9:0] sp;
    input [9:0] ep;
    begin
        if (p[9:0] != ec)
            adv = {p[19:10], p[9:0] + 10'h001};
        else if (p[19:10] != ep)
            adv = {p[19:10] + 10'h001, sc};
        else
            adv = {sp, sc};
    end
endfunction

// =====================================================
// storage
reg [7:0] cfg_q [0:`DCD_CFG_DEPTH-1];
reg [7:0] cmd_q;
reg [3:0] idx_q;
reg wr_pend_q;
reg [7:0] woff_q;
reg [1:0] rcnt_q;
reg [7:0] roff_q;
reg [31:0] hrdata_q;
reg hreadyout_q;
reg hresp_q;
reg [19:0] wptr_q;
reg [19:0] rptr_q;
reg [19:0] mem_addr_q;
reg [23:0] mem_wdata_q;
reg mem_we_q;
reg mem_re_q;
reg [1:0] tear_sel_q;
reg tear_q;
reg deep_sleep_q;
reg clk_sel_q;
reg [3:0] gpio_s1_q;
reg [3:0] gpio_s2_q;
reg lock_s1_q;
reg lock_s2_q;
reg [3:0] gpio_q;
reg [3:0] gpio_oe_q;
reg [7:0] gcnt_q [0:3];
reg [3:0] gen_q;
reg [31:0] rd_d;
integer k;

// =====================================================
// decoded settings
wire [9:0] sc = {cfg_q[{`DCD_S_CASET, `DCD_B0}][1:0],
    cfg_q[{`DCD_S_CASET, `DCD_B1}]};
wire [9:0] ec = {cfg_q[{`DCD_S_CASET, `DCD_B2}][1:0],
    cfg_q[{`DCD_S_CASET, `DCD_B3}]};
wire [9:0] sp = {cfg_q[{`DCD_S_PASET, `DCD_B0}][1:0],
    cfg_q[{`DCD_S_PASET, `DCD_B1}]};
wire [9:0] ep = {cfg_q[{`DCD_S_PASET, `DCD_B2}][1:0],
    cfg_q[{`DCD_S_PASET, `DCD_B3}]};
wire [15:0] tear_line = {cfg_q[{`DCD_S_TLINE, `DCD_B0}],
    cfg_q[{`DCD_S_TLINE, `DCD_B1}]};
wire [3:0] pin_panel = cfg_q[{`DCD_S_PCONF, `DCD_B0}][3:0];
wire [3:0] pin_out = cfg_q[{`DCD_S_PCONF, `DCD_B1}][3:0];
wire [3:0] pin_val = cfg_q[{`DCD_S_PVAL, `DCD_B0}][3:0];
wire [7:0] pll_go = cfg_q[{`DCD_S_PLLGO, `DCD_B0}];
wire [3:0] pin_stat = (~pin_out & ~pin_panel & gpio_s2_q)
    | ((pin_out | pin_panel) & gpio_q);
wire mem_wr_cmd = (cmd_q == `DCD_C_WRS) || (cmd_q == `DCD_C_WRC);
wire mem_rd_cmd = (cmd_q == `DCD_C_RDS) || (cmd_q == `DCD_C_RDC);
wire [4:0] set_sl = slot_of(cmd_q);
wire [4:0] get_sl = get_slot(cmd_q);
wire acc = hsel_i & htrans_i[1] & hready_i;
wire [7:0] woff_d = haddr_i[7:0];
wire cmd_wr = wr_pend_q && woff_q == `DCD_OFF_CMD;
wire dat_wr = wr_pend_q && woff_q == `DCD_OFF_DATA;
wire [7:0] wcmd = hwdata_i[7:0];

// =====================================================
// read data selection
always @*
begin
    rd_d = `DCD_RST_WORD;
    case (roff_q)
        `DCD_OFF_CMD: rd_d[7:0] = cmd_q;
        `DCD_OFF_STAT:
        begin
            rd_d[`DCD_ST_SLEEP] = deep_sleep_q;
            rd_d[`DCD_ST_LOCK] = lock_s2_q;
            rd_d[`DCD_ST_CSEL] = clk_sel_q;
            rd_d[`DCD_ST_CMD+7:`DCD_ST_CMD] = cmd_q;
        end
        `DCD_OFF_DATA:
        begin
            if (mem_rd_cmd)
                rd_d[23:0] = mem_rdata_i;
            else if (cmd_q == `DCD_C_SCAN)
                rd_d[7:0] = (idx_q == `DCD_B0) ? scan_line_i[15:8]
                    : scan_line_i[7:0];
            else if (cmd_q == `DCD_C_PLLST)
                rd_d[0] = lock_s2_q;
            else if (cmd_q == `DCD_C_PSTAT)
                rd_d[3:0] = pin_stat;
            else if (get_sl != `DCD_S_NONE)
                rd_d[7:0] = cfg_q[{get_sl, idx_q}];
        end
        default: rd_d = `DCD_RST_WORD;
    endcase
end

// =====================================================
// bus slave and command execution
always @(posedge sys_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        for (k = 0; k < `DCD_CFG_DEPTH; k = k + 1)
            cfg_q[k] <= `DCD_RST_BYTE;
        cmd_q <= `DCD_RST_BYTE;
        idx_q <= `DCD_B0;
        wr_pend_q <= 1'b0;
        woff_q <= `DCD_RST_BYTE;
        rcnt_q <= 2'h0;
        roff_q <= `DCD_RST_BYTE;
        hrdata_q <= `DCD_RST_WORD;
        hreadyout_q <= 1'b1;
        hresp_q <= 1'b0;
        wptr_q <= 20'h00000;
        rptr_q <= 20'h00000;
        mem_addr_q <= 20'h00000;
        mem_wdata_q <= 24'h000000;
        mem_we_q <= 1'b0;
        mem_re_q <= 1'b0;
        tear_sel_q <= `DCD_TEAR_OFF;
        deep_sleep_q <= 1'b0;
    end
    else
    begin
        mem_we_q <= 1'b0;
        mem_re_q <= 1'b0;
        wr_pend_q <= 1'b0;
        // address phase: writes wait one cycle, reads two
        if (acc)
        begin
            hreadyout_q <= 1'b0;
            if (hwrite_i)
            begin
                wr_pend_q <= 1'b1;
                woff_q <= woff_d;
            end
            else
            begin
                rcnt_q <= `DCD_RD_WAIT;
                roff_q <= woff_d;
                if (woff_d == `DCD_OFF_DATA && mem_rd_cmd)
                begin
                    mem_re_q <= 1'b1;
                    mem_addr_q <= rptr_q;
                    rptr_q <= adv(rptr_q, sc, ec, sp, ep);
                end
            end
        end
        if (wr_pend_q)
            hreadyout_q <= 1'b1;
        if (rcnt_q != 2'h0)
        begin
            rcnt_q <= rcnt_q - 2'h1;
            if (rcnt_q == 2'h1)
            begin
                hrdata_q <= rd_d;
                hreadyout_q <= 1'b1;
                if (roff_q == `DCD_OFF_DATA && !mem_rd_cmd
                    && idx_q != `DCD_IDX_LAST)
                    idx_q <= idx_q + 4'h1;
            end
        end
        // command byte opens a new parameter sequence
        if (cmd_wr)
        begin
            cmd_q <= wcmd;
            idx_q <= `DCD_B0;
            deep_sleep_q <= (wcmd == `DCD_C_SLEEP);
            if (wcmd == `DCD_C_WRS)
                wptr_q <= {sp, sc};
            if (wcmd == `DCD_C_RDS)
                rptr_q <= {sp, sc};
            if (wcmd == `DCD_C_TOFF)
                tear_sel_q <= `DCD_TEAR_OFF;
            if (wcmd == `DCD_C_TON)
                tear_sel_q <= `DCD_TEAR_VFP;
            if (wcmd == `DCD_C_TLINE)
                tear_sel_q <= `DCD_TEAR_LINE;
        end
        // parameter or pixel data
        if (dat_wr)
        begin
            if (mem_wr_cmd)
            begin
                mem_we_q <= 1'b1;
                mem_addr_q <= wptr_q;
                mem_wdata_q <= hwdata_i[23:0];
                wptr_q <= adv(wptr_q, sc, ec, sp, ep);
            end
            else if (set_sl != `DCD_S_NONE)
            begin
                cfg_q[{set_sl, idx_q}] <= wcmd;
                if (idx_q != `DCD_IDX_LAST)
                    idx_q <= idx_q + 4'h1;
            end
        end
    end
end

// =====================================================
// tear pulse, clock select, synchronisers
always @(posedge sys_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        tear_q <= 1'b0;
        clk_sel_q <= 1'b0;
        gpio_s1_q <= 4'h0;
        gpio_s2_q <= 4'h0;
        lock_s1_q <= 1'b0;
        lock_s2_q <= 1'b0;
    end
    else
    begin
        gpio_s1_q <= gpio_i;
        gpio_s2_q <= gpio_s1_q;
        lock_s1_q <= pll_lock_i;
        lock_s2_q <= lock_s1_q;
        tear_q <= (tear_sel_q == `DCD_TEAR_VFP && vfp_start_i)
            || (tear_sel_q == `DCD_TEAR_LINE && line_start_i
            && scan_line_i == tear_line);
        // crystal clock until pll_go bits 0 and 1 are set and pll locked
        clk_sel_q <= pll_go[1] & pll_go[0] & lock_s2_q;
    end
end

// =====================================================
// panel signal generators and pin combining
always @(posedge sys_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        for (k = 0; k < 4; k = k + 1)
            gcnt_q[k] <= `DCD_RST_BYTE;
        gen_q <= 4'h0;
        gpio_q <= 4'h0;
        gpio_oe_q <= 4'h0;
    end
    else
    begin
        gpio_oe_q <= pin_out | pin_panel;
        for (k = 0; k < 4; k = k + 1)
        begin
            // rise, fall, period, enable per generator
            if (gcnt_q[k] >= cfg_q[{`DCD_S_GEN0 + k[4:0], `DCD_B2}])
                gcnt_q[k] <= `DCD_RST_BYTE;
            else
                gcnt_q[k] <= gcnt_q[k] + 8'h01;
            gen_q[k] <= cfg_q[{`DCD_S_GEN0 + k[4:0], `DCD_B3}][0]
                && gcnt_q[k] >= cfg_q[{`DCD_S_GEN0 + k[4:0], `DCD_B0}]
                && gcnt_q[k] < cfg_q[{`DCD_S_GEN0 + k[4:0], `DCD_B1}];
            // byte0 raster code, byte1 operand generator picks
            if (pin_panel[k])
                gpio_q[k] <= cfg_q[{`DCD_S_COMB0 + k[4:0], `DCD_B0}][{
                    gen_q[cfg_q[{`DCD_S_COMB0 + k[4:0], `DCD_B1}][5:4]],
                    gen_q[cfg_q[{`DCD_S_COMB0 + k[4:0], `DCD_B1}][3:2]],
                    gen_q[cfg_q[{`DCD_S_COMB0 + k[4:0], `DCD_B1}][1:0]]
                    }];
            else
                gpio_q[k] <= pin_val[k];
        end
    end
end

// =====================================================
// outputs
assign hrdata_o = hrdata_q;
assign hreadyout_o = hreadyout_q;
assign hresp_o = hresp_q;
assign mem_addr_o = mem_addr_q;
assign mem_wdata_o = mem_wdata_q;
assign mem_we_o = mem_we_q;
assign mem_re_o = mem_re_q;
assign tear_o = tear_q;
assign gpio_o = gpio_q;
assign gpio_oe_o = gpio_oe_q;
assign gen_o = gen_q;
assign addr_mode_o = cfg_q[{`DCD_S_AMODE, `DCD_B0}];
assign panel_mode_o = {cfg_q[{`DCD_S_PMODE, `DCD_B0}],
    cfg_q[{`DCD_S_PMODE, `DCD_B1}]};
assign vert_total_o = {cfg_q[{`DCD_S_VPER, `DCD_B0}],
    cfg_q[{`DCD_S_VPER, `DCD_B1}]};
assign vert_start_o = {cfg_q[{`DCD_S_VPER, `DCD_B2}],
    cfg_q[{`DCD_S_VPER, `DCD_B3}]};
assign post_proc_o = {cfg_q[{`DCD_S_POST, `DCD_B0}],
    cfg_q[{`DCD_S_POST, `DCD_B1}], cfg_q[{`DCD_S_POST, `DCD_B2}],
    cfg_q[{`DCD_S_POST, `DCD_B3}]};
assign bl_conf_o = cfg_q[{`DCD_S_BLCONF, `DCD_B0}];
assign pll_en_o = pll_go[0];
assign clk_sel_pll_o = clk_sel_q;
assign pll_cfg_o = {cfg_q[{`DCD_S_PLLCF, `DCD_B0}],
    cfg_q[{`DCD_S_PLLCF, `DCD_B1}],
    cfg_q[{`DCD_S_PLLCF, `DCD_B2}]};
assign pixclk_cfg_o = {cfg_q[{`DCD_S_PCLK, `DCD_B0}],
    cfg_q[{`DCD_S_PCLK, `DCD_B1}],
    cfg_q[{`DCD_S_PCLK, `DCD_B2}]};
assign deep_sleep_o = deep_sleep_q;

endmodule // dcd_cmd_decoder

// ### hdl/dcd_defs.vh
// constants for the display command decoder
// Operation
// - write resume continues after last written pixel
// - read resume continues after last read pixel
// - tear pulse when refresh reaches set line
// - scan-line query returns current refresh line
// - pin config sets direction or panel use
// - pin value drives only output pins
// - pin status: input level or programmed value; panel pins report their combined generator output
// - panel pins combine generators by raster op
// - four generators, programmable and read back
// - run crystal clock until pll start
// - pll settings accepted, lock status readable
// - deep-sleep command enters deep sleep
// - pixel clock frequency set and read back
// - panel mode set, query returns it
// - vertical period shapes every later frame
// - backlight config and level limits accepted
// - post-processor config alters panel image
// - address order sets panel readout order
// - write start begins at extent start
// - tear-on pulse at front porch start, tear off after reset
`ifndef DCD_DEFS_VH
`define DCD_DEFS_VH
// register offsets
`define DCD_OFF_CMD 8'h00
`define DCD_OFF_DATA 8'h04
`define DCD_OFF_STAT 8'h08
// reset values and sizes
`define DCD_RST_BYTE 8'h00
`define DCD_RST_WORD 32'h0000_0000
`define DCD_CFG_DEPTH 352
`define DCD_IDX_LAST 4'hF
`define DCD_RD_WAIT 2'h2
// tear selection
`define DCD_TEAR_OFF 2'h0
`define DCD_TEAR_VFP 2'h1
`define DCD_TEAR_LINE 2'h2
// command codes
`define DCD_C_CASET 8'h2A
`define DCD_C_PASET 8'h2B
`define DCD_C_WRS 8'h2C
`define DCD_C_RDS 8'h2E
`define DCD_C_TOFF 8'h34
`define DCD_C_TON 8'h35
`define DCD_C_AMODE 8'h36
`define DCD_C_GAMODE 8'h0B
`define DCD_C_WRC 8'h3C
`define DCD_C_RDC 8'h3E
`define DCD_C_TLINE 8'h44
`define DCD_C_SCAN 8'h45
`define DCD_C_PMODE 8'hB0
`define DCD_C_GETMIN 8'hB1
`define DCD_C_VPER 8'hB6
`define DCD_C_PCONF 8'hB8
`define DCD_C_PVAL 8'hBA
`define DCD_C_PSTAT 8'hBB
`define DCD_C_POST 8'hBC
`define DCD_C_GENGRP 4'hC
`define DCD_C_BLCONF 8'hD0
`define DCD_C_BLLIM 8'hD4
`define DCD_C_PLLGO 8'hE0
`define DCD_C_PLLCF 8'hE2
`define DCD_C_PLLST 8'hE4
`define DCD_C_SLEEP 8'hE5
`define DCD_C_PCLK 8'hE6
// parameter storage slots
`define DCD_S_CASET 5'd0
`define DCD_S_PASET 5'd1
`define DCD_S_AMODE 5'd2
`define DCD_S_TLINE 5'd3
`define DCD_S_PMODE 5'd4
`define DCD_S_VPER 5'd5
`define DCD_S_PCONF 5'd6
`define DCD_S_PVAL 5'd7
`define DCD_S_POST 5'd8
`define DCD_S_GEN0 5'd9
`define DCD_S_COMB0 5'd13
`define DCD_S_BLCONF 5'd17
`define DCD_S_BLLIM 5'd18
`define DCD_S_PLLGO 5'd19
`define DCD_S_PLLCF 5'd20
`define DCD_S_PCLK 5'd21
`define DCD_S_NONE 5'd31
// byte positions inside a slot
`define DCD_B0 4'd0
`define DCD_B1 4'd1
`define DCD_B2 4'd2
`define DCD_B3 4'd3
// status word bit positions
`define DCD_ST_SLEEP 0
`define DCD_ST_LOCK 1
`define DCD_ST_CSEL 2
`define DCD_ST_CMD 8
`endif

// ### testbench/dcd_cmd_decoder_monitor.sv
// assertion checker for the display command decoder
`timescale 1ns/1ps
module dcd_cmd_decoder_monitor (
    input wire sys_clk_i,
    input wire rst_i,
    input wire hsel_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire hready_i,
    input wire [31:0] hwdata_i,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire mem_we_o,
    input wire mem_re_o,
    input wire [23:0] mem_wdata_o,
    input wire line_start_i,
    input wire vfp_start_i,
    input wire tear_o,
    input wire pll_en_o,
    input wire clk_sel_pll_o,
    input wire deep_sleep_o
);
    wire acc = hsel_i & htrans_i[1] & hready_i;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // ========================================
    // bus timing
    property p_wr_wait;
        acc && hwrite_i |=> !hreadyout_o ##1 hreadyout_o;
    endproperty
    a_wr_wait: assert property (p_wr_wait) else $error("write wait wrong");
    property p_rd_wait;
        acc && !hwrite_i |=> !hreadyout_o [*2] ##1 hreadyout_o;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_okay;
        hreadyout_o |-> hresp_o == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    // ========================================
    // frame memory
    property p_we_pulse;
        mem_we_o |-> $past(!hreadyout_o) && !$past(mem_we_o);
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("bad write pulse");
    property p_we_data;
        mem_we_o |-> {8'h00, mem_wdata_o} == ($past(hwdata_i) & 32'h00FF_FFFF);
    endproperty
    a_we_data: assert property (p_we_data) else $error("bad pixel");
    property p_re_wait;
        mem_re_o |-> !hreadyout_o ##1 !hreadyout_o ##1 hreadyout_o;
    endproperty
    a_re_wait: assert property (p_re_wait) else $error("bad read pulse");
    // ========================================
    // events and modes
    property p_tear_cause;
        tear_o |-> ($past(vfp_start_i) || $past(line_start_i)) ##1 !tear_o;
    endproperty
    a_tear_cause: assert property (p_tear_cause) else $error("stray tear");
    property p_pll_switch;
        $rose(clk_sel_pll_o) |-> pll_en_o;
    endproperty
    a_pll_switch: assert property (p_pll_switch) else $error("early switch");
    property p_sleep;
        $rose(deep_sleep_o) |-> ($past(hwdata_i) & 32'hFF) == 32'hE5;
    endproperty
    a_sleep: assert property (p_sleep) else $error("stray sleep");
endmodule // dcd_cmd_decoder_monitor

// ### testbench/dcd_cmd_decoder_tb_top.sv
// self-checking bench for the display command decoder
`timescale 1ns/1ps
module dcd_cmd_decoder_tb_top;
    logic clk, rst, hsel, hwrite;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata;
    logic [3:0] gpio_in;
    wire [31:0] hrdata;
    wire hready, hresp, mem_we, mem_re, tear, pll_en, clk_sel, sleep;
    wire pll_lock, lstart, vertical_front_porch;
    wire [19:0] maddr;
    wire [23:0] mwd, mrd;
    wire [15:0] scan;
    wire [3:0] gpo, gpoe, gen;
    wire [7:0] amode, blconf;
    int n_fail = 0;
    int comparisons = 0;
    int n_tear = 0;
    logic [15:0] tear_line;
    dcd_cmd_decoder u_dut (.sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_we_o(mem_we),
        .mem_re_o(mem_re), .mem_rdata_i(mrd), .scan_line_i(scan),
        .line_start_i(lstart), .vfp_start_i(vertical_front_porch), .tear_o(tear),
        .gpio_i(gpio_in), .gpio_o(gpo), .gpio_oe_o(gpoe), .gen_o(gen),
        .addr_mode_o(amode), .panel_mode_o(), .vert_total_o(),
        .vert_start_o(), .post_proc_o(), .bl_conf_o(blconf),
        .pll_lock_i(pll_lock), .pll_en_o(pll_en), .clk_sel_pll_o(clk_sel),
        .pll_cfg_o(), .pixclk_cfg_o(), .deep_sleep_o(sleep));
    dcd_panel_model u_model (.sys_clk_i(clk), .rst_i(rst),
        .mem_addr_i(maddr), .mem_wdata_i(mwd), .mem_we_i(mem_we),
        .mem_re_i(mem_re), .mem_rdata_o(mrd), .scan_line_o(scan),
        .line_start_o(lstart), .vfp_start_o(vertical_front_porch), .pll_en_i(pll_en),
        .pll_lock_o(pll_lock));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (tear === 1'b1)
        begin
            n_tear++;
            tear_line <= scan;
        end
    end
    // ========================================
    // helpers
    task stop_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask
    // command byte then its parameters, byte 0 first
    task cmd(input logic [7:0] c, input int n, input logic [31:0] b);
        wr(8'h00, {24'h000000, c});
        for (int i = 0; i < n; i++) wr(8'h04, {24'h000000, b[8*i+:8]});
    endtask
    task get(input logic [7:0] c, input int n, output logic [31:0] v);
        logic [31:0] r;
        v = 32'h0;
        wr(8'h00, {24'h000000, c});
        for (int i = 0; i < n; i++)
        begin
            bus(8'h04, 1'b0, 32'h0, r);
            v[8*i+:8] = r[7:0];
        end
    endtask
    // ========================================
    // scenarios
    task t_reset;
        logic [31:0] v;
        chk("ready", hready, 32'h1);
        wr(8'h0C, 32'hFFFF_FFFF);
        bus(8'h0C, 1'b0, 32'h0, v);
        chk("unmapped", v, 32'h0);
        get(8'hE3, 3, v);
        chk("pll default", v, 32'h0);
    endtask
    task t_mem;
        logic [31:0] v;
        cmd(8'h2A, 4, 32'h0100_0000);
        cmd(8'h2B, 4, 32'h0100_0000);
        cmd(8'h2C, 0, 32'h0);
        for (int i = 0; i < 3; i++) wr(8'h04, 32'h005A_0000 + i);
        cmd(8'h3C, 0, 32'h0);
        wr(8'h04, 32'h005A_0003);
        // last pixel lands one edge after the bus answer
        @(negedge clk);
        for (int i = 0; i < 4; i++)
            chk("pixel", u_model.mem[{1'b0, i[1], 1'b0, i[0]}], 32'h5A_0000 + i);
        for (int i = 0; i < 4; i++)
        begin
            if (i % 2 == 0)
                cmd((i == 0) ? 8'h2E : 8'h3E, 0, 32'h0);
            bus(8'h04, 1'b0, 32'h0, v);
            chk("read pixel", v & 32'hFF_FFFF, 32'h5A_0000 + i);
        end
    endtask
    task tear_run(input logic [7:0] c, input int n, input logic [31:0] b,
        input int exp);
        cmd(c, n, b);
        @(negedge clk);
        n_tear = 0;
        repeat (80) @(negedge clk);
        chk("tear count", n_tear, exp);
    endtask
    task t_tear;
        logic [31:0] v;
        tear_run(8'h35, 0, 32'h0, 2);
        tear_run(8'h44, 2, 32'h0300, 2);
        chk("tear line", tear_line, 32'h3);
        tear_run(8'h34, 0, 32'h0, 0);
        get(8'h45, 2, v);
        chk("scan", {v[7:0], v[15:8]} < 16'd10, 32'h1);
    endtask
    task t_gpio;
        logic [31:0] v;
        int hi;
        cmd(8'hB8, 2, 32'h0308);
        cmd(8'hBA, 1, 32'h05);
        // pin drive and enable follow the stored bytes one edge later
        @(negedge clk);
        chk("pin enable", gpoe, 32'hB);
        chk("pin drive", gpo[1:0], 32'h1);
        cmd(8'hCE, 2, 32'h00FF);
        cmd(8'hC8, 2, 32'h0000);
        chk("combined pin", gpo[3], 32'h1);
        chk("plain pin", gpo[0], 32'h1);
        get(8'hBB, 1, v);
        chk("pin status", v & 32'hF, 32'h9);
        cmd(8'hC0, 4, 32'h0104_0200);
        hi = 0;
        repeat (20) @(negedge clk) hi += gen[0];
        chk("generator toggles", hi > 0 && hi < 20, 32'h1);
    endtask
    task t_params;
        logic [7:0] codes [8] = '{8'hB0, 8'hB6, 8'hBC, 8'hC6, 8'hD0,
            8'hD4, 8'hE2, 8'hE6};
        int nb [8] = '{2, 4, 4, 4, 1, 1, 3, 3};
        logic [31:0] val, v;
        for (int i = 0; i < 8; i++)
        begin
            val = (32'h5A3C_9681 ^ (i * 32'h0101_0101)) >> (32 - 8 * nb[i]);
            cmd(codes[i], nb[i], val);
            get(codes[i] + 8'h01, nb[i], v);
            chk("readback", v, val);
            if (codes[i] == 8'hD0)
                chk("backlight", blconf, val);
        end
        cmd(8'h36, 1, 32'h2D);
        chk("address order", amode, 32'h2D);
        get(8'h0B, 1, v);
        chk("address order get", v, 32'h2D);
    endtask
    task t_pll;
        logic [31:0] v;
        int n;
        get(8'hE4, 1, v);
        chk("unlocked", v & 32'h1, 32'h0);
        chk("crystal clock", clk_sel, 32'h0);
        cmd(8'hE0, 1, 32'h03);
        n = 0;
        while (clk_sel !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        chk("pll clock", {pll_en, clk_sel}, 32'h3);
        get(8'hE4, 1, v);
        chk("locked", v & 32'h1, 32'h1);
        bus(8'h08, 1'b0, 32'h0, v);
        chk("status pll", v & 32'h6, 32'h6);
    endtask
    task t_sleep;
        logic [31:0] v;
        cmd(8'hE5, 0, 32'h0);
        chk("sleep", sleep, 32'h1);
        bus(8'h08, 1'b0, 32'h0, v);
        chk("status sleep", v & 32'hFF01, 32'hE501);
        cmd(8'h00, 0, 32'h0);
        chk("wake", sleep, 32'h0);
    endtask
    // ========================================
    // main sequence and watchdog
    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        gpio_in = 4'hA;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_mem();
        t_tear();
        t_gpio();
        t_params();
        t_pll();
        t_sleep();
        stop_test();
    end
    initial
    begin
        #(8 * 60000);
        n_fail++;
        $display("watchdog expired");
        stop_test();
    end
endmodule // dcd_cmd_decoder_tb_top
bind dcd_cmd_decoder dcd_cmd_decoder_monitor u_mon (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hready_i(hready_i), .hwdata_i(hwdata_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .mem_we_o(mem_we_o),
    .mem_re_o(mem_re_o), .mem_wdata_o(mem_wdata_o),
    .line_start_i(line_start_i), .vfp_start_i(vfp_start_i),
    .tear_o(tear_o), .pll_en_o(pll_en_o), .clk_sel_pll_o(clk_sel_pll_o),
    .deep_sleep_o(deep_sleep_o));

// ### testbench/dcd_panel_model.sv
// far side model: frame memory, panel scan timing, pll lock
`timescale 1ns/1ps
module dcd_panel_model (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [19:0] mem_addr_i,
    input wire [23:0] mem_wdata_i,
    input wire mem_we_i,
    input wire mem_re_i,
    output logic [23:0] mem_rdata_o,
    output logic [15:0] scan_line_o,
    output logic line_start_o,
    output logic vfp_start_o,
    input wire pll_en_i,
    output logic pll_lock_o
);
    logic [23:0] mem [0:15];
    logic [1:0] lcnt;
    logic [7:0] lock_cnt;
    wire [3:0] idx = {mem_addr_i[11:10], mem_addr_i[1:0]};
    // ========================================
    // 4 cycles a line, 10 lines a frame
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lcnt <= 2'h0;
            scan_line_o <= 16'h0000;
            line_start_o <= 1'b0;
            vfp_start_o <= 1'b0;
            mem_rdata_o <= 24'h000000;
            lock_cnt <= 8'h00;
            pll_lock_o <= 1'b0;
        end
        else
        begin
            lcnt <= lcnt + 2'h1;
            line_start_o <= (lcnt == 2'h3);
            vfp_start_o <= (lcnt == 2'h3) && (scan_line_o == 16'h0007);
            if (lcnt == 2'h3)
                scan_line_o <= (scan_line_o == 16'h0009) ? 16'h0000 :
                    scan_line_o + 16'h0001;
            if (mem_we_i)
                mem[idx] <= mem_wdata_i;
            // data valid one cycle only, then it churns
            mem_rdata_o <= mem_re_i ? mem[idx] : ~mem_rdata_o;
            if (!pll_en_i)
                lock_cnt <= 8'h00;
            else if (lock_cnt != 8'h14)
                lock_cnt <= lock_cnt + 8'h01;
            pll_lock_o <= pll_en_i && (lock_cnt == 8'h14);
        end
    end
endmodule // dcd_panel_model
